/* src/rlfru_pkg.sv */
// Package with opcodes, field positions, status bit positions and reset values.
package rlfru_pkg;
    localparam logic [5:0] OPC_THROUGH_CARRY = 6'h0D;
    localparam logic [5:0] OPC_WRAPAROUND    = 6'h11;
    localparam int         OPC_MSB           = 15;
    localparam int         OPC_LSB           = 10;
    localparam int         DEST_BIT          = 9;
    localparam int         BANK_BIT          = 8;
    localparam int         FADDR_MSB         = 7;
    localparam int         STAT_C            = 0;
    localparam int         STAT_Z            = 2;
    localparam int         STAT_N            = 4;
    localparam logic [7:0] WACC_RESET        = 8'h00;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [7:0] ACCESS_BANK       = 8'h00;
    localparam logic [3:0] BANK_PTR_RESET    = 4'h0;
    localparam logic [11:0] ADDR_WACC        = 12'h000;
    localparam logic [11:0] ADDR_STATUS      = 12'h004;
    localparam logic [11:0] ADDR_BANK        = 12'h008;
    localparam logic [11:0] ADDR_STATE       = 12'h00C;
    typedef enum logic [1:0] {
        RLFRU_IDLE  = 2'b00,
        RLFRU_READ  = 2'b01,
        RLFRU_WRITE = 2'b11
    } rlfru_state_t;
endpackage

/* src/rlfru_rotate.sv */
// Combinational rotate-left core with flag results.
module rlfru_rotate (
    input  wire logic [7:0] src,
    input  wire logic       carry_in,
    input  wire logic       through_carry,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            neg,
    output logic            zero
);
    always_comb begin
        // Bit 7 leaves; bit 0 gets the old carry or the wrapped bit 7.
        result    = {src[6:0], through_carry ? carry_in : src[7]}; // [RL1] [RL3]
        carry_out = through_carry ? src[7] : carry_in; // [RL1] [RL3]
        neg       = result[7]; // [RL9]
        zero      = (result == 8'h00); // [RL9]
    end
endmodule

/* src/rlfru_top.sv */
// Rotate-left file register unit with APB access to its control registers.
//
// Overview of operation
// RL1: Through-carry rotate: bit n goes to n+1, bit 7 to carry, carry to bit 0.
// RL2: Through-carry rotate updates carry, negative and zero flags only.
// RL3: Wraparound rotate: shift left, bit 7 to bit 0; only N and Z change.
// RL4: Destination bit 0 writes the working accumulator; file register kept.
// RL5: Destination bit 1 writes the result back to the file register.
// RL6: Bank bit 0 selects the access bank, ignoring the bank pointer.
// RL7: Bank bit 1 selects the bank named by the bank pointer.
// RL8: File field is eight bits, 0 to 255; d and a are single bits.
// RL9: N mirrors result bit 7; Z set when all result bits are zero.
module rlfru_top #(
    parameter int DATA_W = 8,
    parameter int BANK_W = 4
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                instr_valid,
    input  wire logic [15:0]         instr,
    output logic                     instr_ready,
    output logic      [BANK_W+7:0]   file_addr,
    output logic                     file_rd,
    input  wire logic [DATA_W-1:0]   file_rdata,
    output logic                     file_wr,
    output logic      [DATA_W-1:0]   file_wdata,
    output logic                     busy
);
    localparam logic [11:0] ADDR_WACC   = rlfru_pkg::ADDR_WACC;
    localparam logic [11:0] ADDR_STATUS = rlfru_pkg::ADDR_STATUS;
    localparam logic [11:0] ADDR_BANK   = rlfru_pkg::ADDR_BANK;
    localparam logic [11:0] ADDR_STATE  = rlfru_pkg::ADDR_STATE;

    // The rotate core and the register map are built for one byte of data.
    if (DATA_W != 8) begin : g_bad_data_w
        $error("rlfru_top serves only an 8-bit data path.");
    end
    // The bank pointer register holds at most one byte.
    if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank_w
        $error("rlfru_top bank pointer width must be 1 to 8.");
    end
    // The file field must fill the low byte of the instruction word. [RL8]
    if (rlfru_pkg::FADDR_MSB != 7) begin : g_bad_field
        $error("rlfru_top needs an eight-bit file field.");
    end

    rlfru_pkg::rlfru_state_t state_q;
    logic [7:0]              wacc_q;
    logic [7:0]              status_q;
    logic [BANK_W-1:0]       bank_q;
    logic [BANK_W+7:0]       addr_q;
    logic                    dest_q;
    logic                    carry_mode_q;
    logic [7:0]              rot_result;
    logic                    rot_c;
    logic                    rot_n;
    logic                    rot_z;
    logic                    accept;
    logic                    is_rot;
    logic                    apb_wr;
    logic                    apb_hit;

    logic                    sel_wacc;
    logic                    sel_status;
    logic                    sel_bank;
    logic                    sel_state;
    logic                    rot_retire;
    logic [31:0]             prdata_d;
    logic [31:0]             prdata_q;

    function automatic logic opc_match(input logic [15:0] w, input logic [5:0] opc);
        opc_match = (w[rlfru_pkg::OPC_MSB:rlfru_pkg::OPC_LSB] == opc);
    endfunction

    assign is_rot = opc_match(instr, rlfru_pkg::OPC_THROUGH_CARRY)
                  | opc_match(instr, rlfru_pkg::OPC_WRAPAROUND);
    assign instr_ready = (state_q == rlfru_pkg::RLFRU_IDLE);
    // Other opcodes are taken and dropped so the decoder never stalls on them.
    assign accept = instr_valid && instr_ready && is_rot;
    assign busy   = (state_q != rlfru_pkg::RLFRU_IDLE);

    // Sequencer: read the operand, then write the chosen destination.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= rlfru_pkg::RLFRU_IDLE;
        end else begin
            unique case (state_q)
                rlfru_pkg::RLFRU_IDLE: begin
                    if (accept) state_q <= rlfru_pkg::RLFRU_READ;
                end
                rlfru_pkg::RLFRU_READ:  state_q <= rlfru_pkg::RLFRU_WRITE;
                rlfru_pkg::RLFRU_WRITE: state_q <= rlfru_pkg::RLFRU_IDLE;
                default:                state_q <= rlfru_pkg::RLFRU_IDLE;
            endcase
        end
    end

    // Operand address latch.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q       <= '0;
            dest_q       <= 1'b0;
            carry_mode_q <= 1'b0;
        end else if (accept) begin
            // The file field is a full byte, so all 256 locations are reachable. [RL8]
            if (instr[rlfru_pkg::BANK_BIT]) begin
                addr_q <= {bank_q, instr[rlfru_pkg::FADDR_MSB:0]}; // [RL7]
            end else begin
                addr_q <= {rlfru_pkg::ACCESS_BANK[BANK_W-1:0],
                           instr[rlfru_pkg::FADDR_MSB:0]}; // [RL6]
            end
            dest_q       <= instr[rlfru_pkg::DEST_BIT]; // [RL8]
            carry_mode_q <= opc_match(instr, rlfru_pkg::OPC_THROUGH_CARRY);
        end
    end

    assign file_addr = addr_q;
    assign file_rd   = (state_q == rlfru_pkg::RLFRU_READ);
    assign rot_retire = (state_q == rlfru_pkg::RLFRU_READ);

    rlfru_rotate u_rotate (
        .src           (file_rdata),
        .carry_in      (status_q[rlfru_pkg::STAT_C]),
        .through_carry (carry_mode_q),
        .result        (rot_result),
        .carry_out     (rot_c),
        .neg           (rot_n),
        .zero          (rot_z)
    );

    // Result capture for the file register write-back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            file_wdata <= '0;
            file_wr    <= 1'b0;
        end else begin
            file_wr <= (state_q == rlfru_pkg::RLFRU_READ) && dest_q; // [RL5]
            if (state_q == rlfru_pkg::RLFRU_READ) file_wdata <= rot_result; // [RL5]
        end
    end

    // One select per register; an offset that hits none of them answers with an error.
    assign apb_wr     = psel && penable && pwrite;
    assign sel_wacc   = (paddr == ADDR_WACC);
    assign sel_status = (paddr == ADDR_STATUS);
    assign sel_bank   = (paddr == ADDR_BANK);
    assign sel_state  = (paddr == ADDR_STATE);
    assign apb_hit    = sel_wacc || sel_status || sel_bank || sel_state;

    // Working accumulator; the rotate has priority over a same-cycle bus write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wacc_q <= rlfru_pkg::WACC_RESET;
        end else if (rot_retire && !dest_q) begin
            wacc_q <= rot_result; // [RL4]
        end else if (apb_wr && sel_wacc) begin
            wacc_q <= pwdata[7:0];
        end
    end

    // Status flags: only C, N and Z are ever touched by a rotate.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= rlfru_pkg::STATUS_RESET;
        end else if (rot_retire) begin
            status_q[rlfru_pkg::STAT_N] <= rot_n; // [RL9] [RL2] [RL3]
            status_q[rlfru_pkg::STAT_Z] <= rot_z; // [RL9] [RL2] [RL3]
            if (carry_mode_q) status_q[rlfru_pkg::STAT_C] <= rot_c; // [RL2] [RL3]
        end else if (apb_wr && sel_status) begin
            status_q <= pwdata[7:0];
        end
    end

    // Bank pointer; bits above its width do not exist and read as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_q <= BANK_W'(rlfru_pkg::BANK_PTR_RESET);
        end else if (apb_wr && sel_bank) begin
            bank_q <= pwdata[BANK_W-1:0];
        end
    end

    // Every register answers at once, so the bus never sees a wait state.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !apb_hit;

    always_comb begin
        prdata_d = 32'h00000000;
        unique case (paddr)
            ADDR_WACC:   prdata_d[7:0] = wacc_q;
            ADDR_STATUS: prdata_d[7:0] = status_q;
            ADDR_BANK:   prdata_d[BANK_W-1:0] = bank_q;
            ADDR_STATE:  prdata_d[1:0] = state_q;
            default:     prdata_d = 32'h00000000;
        endcase
    end

    // Read data is caught at the end of the setup phase, so it comes from a flip-flop and
    // still needs no wait state. A rotate that retires on that same edge is not seen by
    // the read; software reads the accumulator or the flags once the unit is idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
endmodule

/* test/rlfru_assertions.sv */
// Checker for the rotate unit ports, bound to its top module.
module rlfru_checker #(parameter int DATA_W = 8, parameter int BANK_W = 4) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              instr_valid,
    input wire logic [15:0]       instr,
    input wire logic              instr_ready,
    input wire logic [BANK_W+7:0] file_addr,
    input wire logic              file_rd,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic              file_wr,
    input wire logic [DATA_W-1:0] file_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rot;
    logic wrap;
    assign wrap = instr[15:10] == rlfru_pkg::OPC_WRAPAROUND;
    assign rot = instr_valid && instr_ready
               && (wrap || instr[15:10] == rlfru_pkg::OPC_THROUGH_CARRY);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_read_strobe: assert property (rot |=> file_rd ##1 !file_rd)
        else $error("read strobe not one cycle after accept");
    a_write_back: assert property (rot && instr[9] |=> ##1 file_wr)
        else $error("no write back with d set");
    a_keep_file: assert property (rot && !instr[9] |=> !file_wr ##1 !file_wr)
        else $error("file written with d clear");
    a_access_bank: assert property (rot && !instr[8] |=>
        file_addr[BANK_W+7:8] == '0 && file_addr[7:0] == $past(instr[7:0]))
        else $error("access bank address wrong");
    a_file_field: assert property (rot |=> file_addr[7:0] == $past(instr[7:0]))
        else $error("file field not on address");
    a_wrap_data: assert property (rot && wrap && instr[9] ##1 file_rd |=>
        file_wdata == {$past(file_rdata[6:0]), $past(file_rdata[7])}) else $error("wrap data");
    a_carry_data: assert property (rot && !wrap && instr[9] ##1 file_rd |=>
        file_wdata[7:1] == $past(file_rdata[6:0])) else $error("carry rotate data");
    a_write_pulse: assert property (file_wr |=> !file_wr)
        else $error("write strobe longer than one cycle");
    cover property (rot && wrap);
    cover property (rot && !instr[9]);
    cover property (file_wr);
endmodule
bind rlfru_top rlfru_checker #(.DATA_W(DATA_W), .BANK_W(BANK_W)) u_chk (.pclk, .presetn,
    .instr_valid, .instr, .instr_ready, .file_addr, .file_rd, .file_rdata, .file_wr, .file_wdata);

/* test/testbench.sv */
// Self-checking bench for the rotate unit.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, instr_valid, pready, pslverr;
    logic        instr_ready, file_rd, file_wr, busy;
    logic [11:0] paddr, file_addr;
    logic [31:0] pwdata, prdata, seed;
    logic [15:0] instr;
    logic [7:0]  file_rdata, file_wdata, wacc, st;
    logic [32:0] q_rd[$];
    logic [32:0] q_ad[$];
    logic [32:0] q_wr[$];
    int          fails, n_compared, cyc;
    rlfru_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_valid, .instr, .instr_ready, .file_addr, .file_rd,
        .file_rdata, .file_wr, .file_wdata, .busy);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [32:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rot(input logic thr, d, a, input logic [7:0] f, src);
        logic [7:0] res;
        res = {src[6:0], thr ? st[0] : src[7]};
        st[0] = thr ? src[7] : st[0];
        st[4] = res[7];
        st[2] = res == 8'h00;
        if (d) q_wr.push_back(33'(res));
        else wacc = res;
        q_ad.push_back(33'({a ? 4'h5 : 4'h0, f}));
        @(posedge pclk);
        instr <= {thr ? rlfru_pkg::OPC_THROUGH_CARRY : rlfru_pkg::OPC_WRAPAROUND, d, a, f};
        instr_valid <= 1;
        file_rdata <= src;
        @(posedge pclk);
        while (instr_ready !== 1) @(posedge pclk);
        instr_valid <= 0;
        @(posedge pclk);
        file_rdata <= ~src;
        @(posedge pclk);
        q_rd.push_back({25'h0, wacc});
        apb(0, 12'h000, 32'h0);
        q_rd.push_back({25'h0, st});
        apb(0, 12'h004, 32'h0);
    endtask
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready && !pwrite) begin
            chk("apb", {pslverr, prdata}, q_rd.pop_front());
            chk("busy_ready", 33'({busy, instr_ready}), 33'h001);
        end
        if (file_rd) begin
            chk("file_addr", 33'(file_addr), q_ad.pop_front());
            chk("busy_ready", 33'({busy, instr_ready}), 33'h002);
        end
        if (file_wr) chk("file_wdata", 33'(file_wdata), q_wr.pop_front());
        if (cyc > 4000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        logic [31:0] r;
        {presetn, psel, penable, pwrite, paddr, pwdata, instr_valid, instr} = '0;
        {file_rdata, wacc, st, fails, n_compared, cyc} = '0;
        seed = 32'h0000001A;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        q_rd.push_back({1'b1, 32'h0});
        apb(0, 12'h010, 32'h0);
        apb(1, 12'h008, 32'h5);
        rot(1, 0, 0, 8'h20, 8'hE6);
        rot(0, 1, 1, 8'hFF, 8'h80);
        q_rd.push_back({1'b0, 32'h00000005});
        apb(0, 12'h008, 32'h0);
        @(posedge pclk);
        instr       <= 16'hFFFF;
        instr_valid <= 1'b1;
        @(posedge pclk);
        instr_valid <= 1'b0;
        q_rd.push_back({25'h0, wacc});
        apb(0, 12'h000, 32'h0);
        q_rd.push_back({25'h0, st});
        apb(0, 12'h004, 32'h0);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            st = r[23:16];
            apb(1, 12'h004, 32'(st));
            rot(r[0], r[1], r[2], r[15:8], r[31:24] & {8{r[5]}});
        end
        final_report();
    end
endmodule
